// *** hdl/adc_serial_pkg.sv ***
package adc_serial_pkg;
  // Frame layout, counted in serial clock rising edges
  localparam logic [4:0] FRAME_BITS = 5'h18;
  localparam logic [4:0] CMD_BITS = 5'h08;
  localparam logic [4:0] LAST_DATA_EDGE = 5'h17;
  localparam logic [1:0] RESERVED_PATTERN = 2'h2;
  localparam logic OP_READ = 1'h1;
  localparam logic OP_WRITE = 1'h0;
  localparam logic DONT_CARE_BIT = 1'h0;

  // Converter register map and defaults
  localparam logic [3:0] ADDR_MAIN_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_OFFSET_FIRST = 4'h2;
  localparam logic [3:0] ADDR_FSR_FIRST = 4'h3;
  localparam logic [3:0] ADDR_INTERLEAVE_TIMING = 4'h7;
  localparam logic [3:0] ADDR_OFFSET_SECOND = 4'ha;
  localparam logic [3:0] ADDR_FSR_SECOND = 4'hb;
  localparam logic [3:0] ADDR_PHASE_FIRST = 4'hc;
  localparam logic [3:0] ADDR_PHASE_SECOND = 4'hd;
  localparam logic [3:0] ADDR_EXT_CONFIG = 4'he;
  localparam logic [15:0] REG_DEFAULT = 16'h0000;
  localparam int DES_BIT = 7;

  // Timing of the generated serial clock
  localparam int SYS_PERIOD_NS = 10;
  localparam int SCLK_PERIOD_NS = 160;
  localparam logic [3:0] HALF_CYCLES = 4'(SCLK_PERIOD_NS / (2 * SYS_PERIOD_NS));

  // Controller Avalon-MM registers (byte offsets) and fields
  localparam logic [3:0] CMD_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_ADDR_LSB = 16;
  localparam int CMD_READ_BIT = 20;
  localparam int CMD_3WIRE_BIT = 21;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_DATA_LSB = 16;

  typedef enum logic [2:0] {
    M_IDLE = 3'h0,
    M_SETUP = 3'h1,
    M_HIGH = 3'h3,
    M_LOW = 3'h2,
    M_FINISH = 3'h6,
    M_GAP = 3'h7
  } master_state_t;

  function automatic logic isImplemented(input logic [3:0] addr);
    case (addr)
      ADDR_MAIN_CONFIG, ADDR_OFFSET_FIRST, ADDR_FSR_FIRST, ADDR_INTERLEAVE_TIMING,
      ADDR_OFFSET_SECOND, ADDR_FSR_SECOND, ADDR_PHASE_FIRST, ADDR_PHASE_SECOND,
      ADDR_EXT_CONFIG: isImplemented = 1'b1;
      default: isImplemented = 1'b0;
    endcase
  endfunction
endpackage

// *** hdl/adc_serial_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface adc_serial_if;
  logic serialSelectN;
  logic serialClk;
  logic masterData;
  logic masterDataEn;
  logic deviceData;
  logic deviceDataEn;
  logic threeWire;
  logic serialDataIn;
  logic serialDataOut;

  // Wire levels; undriven lines float high through pull-ups
  assign serialDataIn = masterDataEn ? masterData :
                        ((threeWire && deviceDataEn) ? deviceData : 1'b1);
  assign serialDataOut = threeWire ? serialDataIn : (deviceDataEn ? deviceData : 1'b1);

  modport device (
    input serialSelectN,
    input serialClk,
    input serialDataIn,
    output deviceData,
    output deviceDataEn
  );

  modport master (
    output serialSelectN,
    output serialClk,
    output masterData,
    output masterDataEn,
    input serialDataOut
  );
endinterface
`default_nettype wire

// *** hdl/adc_serial_device.sv ***
`timescale 1ns/1ps
`default_nettype none
// Function
// - Extended control only while select pin low
// - Pin high holds registers at defaults
// - One frame, 24 clocks, one access
// - Register contents kept through power-down
// - Select falling starts access, bit next rise
// - Early select release aborts the access
// - Long read keeps driving bit zero
// - Long write commits at 24th clock
// - Master raises select between accesses
// - Sample on rising, change on falling
// - Any slow or stopped clock tolerated
// - Shared wire: master releases before 8th fall
// - Output driven only during decoded read
// - Read data MSB first from 8th fall
// - Select release floats the output
// - Unimplemented address reads all zeros
// - First bit one reads, zero writes
// - Bits two and three are one-zero
// - Bits four-seven address, bit eight ignored
// - Bits nine-24 carry data, bit 15 first
// - Register zero bit 7 enables dual-edge
module adc_serial_device (
  input wire logic sys_clk,
  input wire logic rst_b,
  adc_serial_if.device link,
  input wire logic extCtrlSelectPin,
  output logic extendedControlMode,
  output logic dualEdgeEnable,
  output logic [15:0] mainConfiguration,
  output logic [15:0] extendedConfiguration
);
  typedef struct packed {
    logic [2:0] selSync;
    logic [2:0] clkSync;
    logic [1:0] dinSync;
    logic [1:0] extSync;
    logic extended_control_mode;
    logic [4:0] count;
    logic [6:0] cmd;
    logic isRead;
    logic [15:0] inShift;
    logic [15:0] outShift;
    logic dout;
    logic doutEn;
    logic [15:0][15:0] regs;
  } dev_state_t;

  dev_state_t state_reg;
  dev_state_t state_next;
  logic rise;
  logic fall;
  logic selected;
  logic din;
  logic [3:0] addr;

  localparam logic [4:0] FRAME_BITS_L = adc_serial_pkg::FRAME_BITS;
  localparam logic [4:0] CMD_BITS_L = adc_serial_pkg::CMD_BITS;

  always_comb
  begin
    state_next = state_reg;
    state_next.selSync = {state_reg.selSync[1:0], link.serialSelectN};
    state_next.clkSync = {state_reg.clkSync[1:0], link.serialClk};
    state_next.dinSync = {state_reg.dinSync[0], link.serialDataIn};
    state_next.extSync = {state_reg.extSync[0], extCtrlSelectPin};
    // Edges found from the second and third flops only
    rise = state_reg.clkSync[1] & ~state_reg.clkSync[2];
    fall = ~state_reg.clkSync[1] & state_reg.clkSync[2];
    selected = ~state_reg.selSync[1];
    din = state_reg.dinSync[1];
    addr = state_reg.cmd[3:0];
    state_next.extended_control_mode = ~state_reg.extSync[1];
    if (!selected)
    begin
      // Partial frame dropped, output floated
      state_next.count = 5'h00;
      state_next.cmd = 7'h00;
      state_next.isRead = 1'b0;
      state_next.inShift = 16'h0000;
      state_next.outShift = 16'h0000;
      state_next.dout = 1'b0;
      state_next.doutEn = 1'b0;
    end
    else
    begin
      // State held between edges, so the clock may stop anywhere
      if (rise && state_reg.count < FRAME_BITS_L)
      begin
        state_next.count = state_reg.count + 5'h01;
        if (state_reg.count < CMD_BITS_L - 5'h01)
        begin
          state_next.cmd = {state_reg.cmd[5:0], din};
        end
        if (state_reg.count == CMD_BITS_L - 5'h01)
        begin
          // Eighth bit is ignored; command is decoded here
          state_next.isRead = (state_reg.cmd[6] == adc_serial_pkg::OP_READ);
          state_next.outShift = adc_serial_pkg::isImplemented(addr) ?
                                state_reg.regs[addr] : 16'h0000;
        end
        if (state_reg.count >= CMD_BITS_L)
        begin
          state_next.inShift = {state_reg.inShift[14:0], din};
        end
        // Commit on the 24th rise only; later clocks change nothing
        if (state_reg.count == adc_serial_pkg::LAST_DATA_EDGE && !state_reg.isRead &&
            state_reg.extended_control_mode && adc_serial_pkg::isImplemented(addr))
        begin
          state_next.regs[addr] = {state_reg.inShift[14:0], din};
        end
      end
      // Shift out on falls 8..23; the last bit then stays on the pin
      if (fall && state_reg.isRead && state_reg.count >= CMD_BITS_L &&
          state_reg.count <= adc_serial_pkg::LAST_DATA_EDGE)
      begin
        state_next.doutEn = 1'b1;
        state_next.dout = state_reg.outShift[15];
        state_next.outShift = {state_reg.outShift[14:0], 1'b0};
      end
    end
    // Registers have no power-down clear; only rst_b and the select pin restore them
    if (state_reg.extSync[1])
    begin
      state_next.regs = {16{adc_serial_pkg::REG_DEFAULT}};
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      state_reg <= '0;
      state_reg.selSync <= 3'h7;
      state_reg.dinSync <= 2'h3;
      state_reg.extSync <= 2'h3;
      state_reg.regs <= {16{adc_serial_pkg::REG_DEFAULT}};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign link.deviceData = state_reg.dout;
  assign link.deviceDataEn = state_reg.doutEn;
  assign extendedControlMode = state_reg.extended_control_mode;
  assign dualEdgeEnable = state_reg.regs[adc_serial_pkg::ADDR_MAIN_CONFIG][adc_serial_pkg::DES_BIT];
  assign mainConfiguration = state_reg.regs[adc_serial_pkg::ADDR_MAIN_CONFIG];
  assign extendedConfiguration = state_reg.regs[adc_serial_pkg::ADDR_EXT_CONFIG];
endmodule
`default_nettype wire

// *** hdl/adc_serial_master.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_serial_master (
  input wire logic sys_clk,
  input wire logic rst_b,
  adc_serial_if.master link,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest
);
  typedef struct packed {
    adc_serial_pkg::master_state_t state;
    logic [3:0] div;
    logic [4:0] bitCount;
    logic [23:0] tx;
    logic [15:0] rx;
    logic [15:0] result;
    logic isRead;
    logic threeWire;
    logic selN;
    logic sclk;
    logic mData;
    logic mDataEn;
    logic busy;
    logic waitReq;
    logic [31:0] rdata;
    logic [1:0] doutSync;
  } master_reg_t;

  master_reg_t state_reg;
  master_reg_t state_next;
  logic tick;

  always_comb
  begin
    state_next = state_reg;
    state_next.doutSync = {state_reg.doutSync[0], link.serialDataOut};
    tick = (state_reg.div == adc_serial_pkg::HALF_CYCLES - 4'h1);
    state_next.div = (tick || state_reg.state == adc_serial_pkg::M_IDLE) ? 4'h0 :
                     state_reg.div + 4'h1;
    // Avalon slave: every access answered one cycle after it appears
    state_next.waitReq = 1'b1;
    if ((read || write) && state_reg.waitReq)
    begin
      state_next.waitReq = 1'b0;
      state_next.rdata = 32'h00000000;
      if (read && address == adc_serial_pkg::STATUS_OFFSET)
      begin
        state_next.rdata[adc_serial_pkg::STATUS_DATA_LSB +: 16] = state_reg.result;
        state_next.rdata[adc_serial_pkg::STATUS_BUSY_BIT] = state_reg.busy;
      end
    end
    // Command launched only at the edge that completes the transfer
    if (write && !state_reg.waitReq && address == adc_serial_pkg::CMD_OFFSET && !state_reg.busy)
    begin
      // Frame: op, reserved 10, address, don't care, data
      state_next.isRead = writedata[adc_serial_pkg::CMD_READ_BIT];
      state_next.threeWire = writedata[adc_serial_pkg::CMD_3WIRE_BIT];
      state_next.tx = {writedata[adc_serial_pkg::CMD_READ_BIT],
                       adc_serial_pkg::RESERVED_PATTERN,
                       writedata[adc_serial_pkg::CMD_ADDR_LSB +: 4],
                       adc_serial_pkg::DONT_CARE_BIT,
                       writedata[adc_serial_pkg::CMD_DATA_LSB +: 16]};
      state_next.mData = writedata[adc_serial_pkg::CMD_READ_BIT];
      state_next.mDataEn = 1'b1;
      state_next.selN = 1'b0;
      state_next.sclk = 1'b0;
      state_next.bitCount = 5'h00;
      state_next.busy = 1'b1;
      state_next.div = 4'h0;
      state_next.state = adc_serial_pkg::M_SETUP;
    end
    case (state_reg.state)
      adc_serial_pkg::M_IDLE:
      begin
      end
      adc_serial_pkg::M_SETUP, adc_serial_pkg::M_LOW:
      begin
        if (tick)
        begin
          // Rising edge: device samples our bit, we sample its bit
          state_next.sclk = 1'b1;
          state_next.rx = {state_reg.rx[14:0], state_reg.doutSync[1]};
          state_next.bitCount = state_reg.bitCount + 5'h01;
          if (state_reg.bitCount == adc_serial_pkg::CMD_BITS - 5'h01 &&
              state_reg.isRead && state_reg.threeWire)
          begin
            state_next.mDataEn = 1'b0;
          end
          state_next.state = adc_serial_pkg::M_HIGH;
        end
      end
      adc_serial_pkg::M_HIGH:
      begin
        if (tick)
        begin
          state_next.sclk = 1'b0;
          state_next.tx = {state_reg.tx[22:0], 1'b0};
          state_next.mData = state_reg.tx[22];
          state_next.state = (state_reg.bitCount == adc_serial_pkg::FRAME_BITS) ?
                             adc_serial_pkg::M_FINISH : adc_serial_pkg::M_LOW;
        end
      end
      adc_serial_pkg::M_FINISH:
      begin
        if (tick)
        begin
          state_next.selN = 1'b1;
          state_next.mData = 1'b1;
          state_next.mDataEn = 1'b1;
          state_next.result = state_reg.isRead ? state_reg.rx : state_reg.result;
          state_next.state = adc_serial_pkg::M_GAP;
        end
      end
      adc_serial_pkg::M_GAP:
      begin
        if (tick)
        begin
          state_next.busy = 1'b0;
          state_next.state = adc_serial_pkg::M_IDLE;
        end
      end
      default:
      begin
        state_next.state = adc_serial_pkg::M_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      state_reg <= '0;
      state_reg.selN <= 1'b1;
      state_reg.mData <= 1'b1;
      state_reg.mDataEn <= 1'b1;
      state_reg.waitReq <= 1'b1;
      state_reg.doutSync <= 2'h3;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign link.serialSelectN = state_reg.selN;
  assign link.serialClk = state_reg.sclk;
  assign link.masterData = state_reg.mData;
  assign link.masterDataEn = state_reg.mDataEn;
  assign readdata = state_reg.rdata;
  assign waitrequest = state_reg.waitReq;
endmodule
`default_nettype wire

// *** bench/adc_serial_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_serial_properties (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic serialSelectN,
  input wire logic serialClk,
  input wire logic masterDataEn,
  input wire logic deviceData,
  input wire logic deviceDataEn,
  input wire logic threeWire,
  input wire logic serialDataIn
);
  logic [4:0] riseCount_reg;
  logic sclkPrev_reg;
  logic opBit_reg;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  // Counts serial clock rises in a frame and keeps the first frame bit
  always_ff @(posedge sys_clk)
  begin
    sclkPrev_reg <= serialClk;
    if (!rst_b || serialSelectN)
      riseCount_reg <= 5'h00;
    else if (serialClk && !sclkPrev_reg)
    begin
      riseCount_reg <= riseCount_reg + 5'h01;
      if (riseCount_reg == 5'h00)
        opBit_reg <= serialDataIn;
    end
  end
  property p_clean_start;
    $fell(serialSelectN) |-> !serialClk [*7];
  endproperty
  a_clean_start: assert property (p_clean_start) else $error("clock rose too soon");
  property p_gap;
    $rose(serialSelectN) |-> serialSelectN [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("select gap too short");
  property p_frame_len;
    $rose(serialSelectN) |-> riseCount_reg == 5'h18;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame not 24 clocks");
  property p_read_start;
    $rose(deviceDataEn) |-> riseCount_reg == 5'h08 && opBit_reg && !serialSelectN;
  endproperty
  a_read_start: assert property (p_read_start) else $error("output enabled wrongly");
  property p_no_clash;
    threeWire && deviceDataEn && !serialSelectN |-> !masterDataEn;
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("both ends drive wire");
  property p_out_change;
    deviceDataEn && $past(deviceDataEn) && $changed(deviceData) |-> !serialClk;
  endproperty
  a_out_change: assert property (p_out_change) else $error("output moved in high");
  property p_hold_out;
    $fell(deviceDataEn) |-> serialSelectN;
  endproperty
  a_hold_out: assert property (p_hold_out) else $error("output dropped early");
  property p_float_soon;
    $rose(serialSelectN) |-> ##[1:6] !deviceDataEn;
  endproperty
  a_float_soon: assert property (p_float_soon) else $error("output not floated");
endmodule
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
  $display("FAIL %0t got %h exp %h", $time, a, b); end end
module tb;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic extPin = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic extended_control_mode;
  logic des;
  logic [15:0] cfg0;
  logic [15:0] cfgE;
  logic [15:0] mainB;
  logic [15:0] q;
  logic [15:0] d;
  logic [31:0] rd;
  logic [29:0] cap;
  int failures = 0;
  int check_count = 0;
  localparam logic [15:0] IMPL = 16'h7c8d;
  adc_serial_if link();
  adc_serial_if link2();
  adc_serial_device i_adc_serial_device (.sys_clk(sys_clk), .rst_b(rst_b), .link(link.device),
    .extCtrlSelectPin(extPin), .extendedControlMode(extended_control_mode), .dualEdgeEnable(des),
    .mainConfiguration(cfg0), .extendedConfiguration(cfgE));
  adc_serial_device i_adc_serial_device_b (.sys_clk(sys_clk), .rst_b(rst_b),
    .link(link2.device), .extCtrlSelectPin(extPin), .extendedControlMode(),
    .dualEdgeEnable(), .mainConfiguration(mainB), .extendedConfiguration());
  adc_serial_master i_adc_serial_master (.sys_clk(sys_clk), .rst_b(rst_b), .link(link.master),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest));
  adc_serial_properties i_adc_serial_properties (.sys_clk(sys_clk), .rst_b(rst_b),
    .serialSelectN(link.serialSelectN), .serialClk(link.serialClk),
    .masterDataEn(link.masterDataEn), .deviceData(link.deviceData),
    .deviceDataEn(link.deviceDataEn), .threeWire(link.threeWire),
    .serialDataIn(link.serialDataIn));
  task automatic close_out;
    $display("failures %0d checks %0d", failures, check_count);
    if (failures == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] rq);
    int n;
    n = 0;
    @(posedge sys_clk);
    address <= a;
    writedata <= wd;
    read <= !wr;
    write <= wr;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 50);
    rq = readdata;
    read <= 1'b0;
    write <= 1'b0;
    `CHK(n < 50, 1'b1)
  endtask
  task automatic spi(input logic op, input logic [3:0] a, input logic [15:0] wd,
                     input logic tw, output logic [15:0] rq);
    int n;
    n = 0;
    link.threeWire <= tw;
    bus(1'b1, 4'h0, {10'h000, tw, op, a, wd}, rd);
    do
    begin
      bus(1'b0, 4'h4, 32'h0, rd);
      n++;
    end
    while (rd[0] !== 1'b0 && n < 300);
    rq = rd[31:16];
    `CHK(n < 300, 1'b1)
    `CHK({link.serialSelectN, link.serialClk}, 2'b10)
  endtask
  // Bit-banged master on the second link, able to send short or long frames
  task automatic bang(input logic [23:0] f, input int clocks, output logic [29:0] c);
    @(posedge sys_clk);
    link2.serialSelectN <= 1'b0;
    link2.masterData <= f[23];
    repeat (8) @(posedge sys_clk);
    for (int i = 0; i < clocks; i++)
    begin
      link2.serialClk <= 1'b1;
      c[29 - i] = link2.serialDataOut;
      repeat (8) @(posedge sys_clk);
      link2.serialClk <= 1'b0;
      link2.masterData <= (i < 23) ? f[22 - i] : 1'b1;
      repeat (8) @(posedge sys_clk);
    end
    link2.serialSelectN <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    #400000;
    failures++;
    close_out();
  end
  initial
  begin
    link.threeWire = 1'b0;
    link2.threeWire = 1'b0;
    link2.serialSelectN = 1'b1;
    link2.serialClk = 1'b0;
    link2.masterData = 1'b1;
    link2.masterDataEn = 1'b1;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    `CHK({extended_control_mode, des}, 2'b10)
    spi(1'b1, 4'h0, 16'h0000, 1'b0, q);
    `CHK(q, 16'h0000)
    for (int a = 0; a < 16; a++)
    begin
      d = {4'h9, 4'(a), ~4'(a), 4'(a)};
      spi(1'b0, 4'(a), d, 1'b0, q);
      spi(1'b1, 4'(a), 16'h0000, a[0], q);
      `CHK(q, IMPL[a] ? d : 16'h0000)
    end
    `CHK({cfg0, cfgE, des}, {16'h90f0, 16'h9e1e, 1'b1})
    bang({1'b0, 2'b10, 4'h0, 1'b0, 16'h1234}, 30, cap);
    `CHK(mainB, 16'h1234)
    bang({1'b1, 2'b10, 4'h0, 1'b0, 16'h0000}, 30, cap);
    `CHK(cap[29:22], 8'hff)
    `CHK(cap[21:6], 16'h1234)
    `CHK(cap[5:0], 6'h00)
    `CHK(link2.deviceDataEn, 1'b0)
    bang({1'b0, 2'b10, 4'h0, 1'b0, 16'hbeef}, 20, cap);
    `CHK(mainB, 16'h1234)
    extPin <= 1'b1;
    repeat (6) @(posedge sys_clk);
    `CHK({extended_control_mode, cfg0, cfgE, mainB}, 49'h0)
    extPin <= 1'b0;
    repeat (6) @(posedge sys_clk);
    spi(1'b1, 4'h2, 16'h0000, 1'b1, q);
    `CHK({extended_control_mode, q}, 17'h10000)
    close_out();
  end
endmodule
`default_nettype wire
